// ### hw/scs_frac_div.sv
// Purpose: fractional-N divider making the 1 kHz reference
// Assumes: slow_tick is a one-cycle pulse per slow rc rising edge
// Notes: output toggles only on a tick, so it never makes a runt pulse
`timescale 1ns/1ps
module scs_frac_div
   import scs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow_tick,
   input wire logic [FRAC_W-1:0] half_ratio,
   output logic ref_clk_reg
);
   logic [FRAC_W:0] acc_reg; // phase accumulator, 1/256 units
   logic [FRAC_W:0] acc_sum; // accumulator plus one slow period
   logic [FRAC_W:0] ratio_eff; // ratio clamped to at least one period

   // ratios under one period would need several toggles per tick
   always_comb begin
      ratio_eff = (half_ratio < FRAC_ONE) ? {1'b0, FRAC_ONE} : {1'b0, half_ratio};
      acc_sum = acc_reg + {1'b0, FRAC_ONE};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= '0;
         ref_clk_reg <= 1'b0;
      end else if (slow_tick) begin
         if (acc_sum >= ratio_eff) begin
            acc_reg <= acc_sum - ratio_eff;
            ref_clk_reg <= ~ref_clk_reg;
         end else begin
            acc_reg <= acc_sum;
         end
      end
   end

   a_ref_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(ref_clk_reg) |-> $past(slow_tick))
      else $error("1 kHz reference moved without a slow rc edge");
endmodule : scs_frac_div

// ### hw/scs_pkg.sv
// Purpose: shared constants for the system clock switching block
// Assumes: 32-bit apb data, pclk at 100 MHz
// Notes: offsets are byte addresses, one aligned word per register
package scs_pkg;
   // clock and timing base
   localparam int CLK_PERIOD_NS = 10;
   localparam int XTAL_START_MAX_BIAS_MS = 1;            // start-up ceiling at max bias
   localparam int XTAL_START_OPT_BIAS_MS = 2;            // start-up ceiling at optimal bias
   localparam int XTAL_START_MAX_CYC = XTAL_START_MAX_BIAS_MS * 1000000 / CLK_PERIOD_NS;
   localparam int XTAL_START_OPT_CYC = XTAL_START_OPT_BIAS_MS * 1000000 / CLK_PERIOD_NS;
   localparam int XTAL_FAIL_NS = 640;                   // no crystal edge for this long is a failure
   localparam int XTAL_FAIL_CYC = (XTAL_FAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAST_RC_STEP_KHZ = 300;               // one trim code step of the fast rc
   // register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TRIM_OFS = 8'h04;
   localparam logic [7:0] FRAC_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
   // ctrl fields
   localparam int CTRL_OSC_SEL_BIT = 0;
   localparam int CTRL_CPU_SEL_BIT = 1;
   localparam int CTRL_XTAL_EN_BIT = 2;
   localparam int CTRL_PIN_DIG_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // trim fields
   localparam int TRIM_RC_LSB = 0;
   localparam int TRIM_RC_W = 5;
   localparam int TRIM_BIAS_LSB = 8;
   localparam int TRIM_BIAS_W = 4;
   localparam logic [4:0] TRIM_RC_RESET = 5'h10;
   localparam logic [3:0] TRIM_BIAS_RESET = 4'hf;
   localparam logic [3:0] TRIM_BIAS_MAX = 4'hf;
   // fractional divider: half period of the 1 kHz ref in 1/256 slow rc periods
   localparam int FRAC_W = 16;
   localparam logic [15:0] FRAC_ONE = 16'h0100;
   localparam logic [15:0] FRAC_RESET = 16'h0500;
   // status and interrupt fields
   localparam int STAT_ON_XTAL_BIT = 0;
   localparam int STAT_XTAL_RDY_BIT = 1;
   localparam int STAT_FLASH_BIT = 2;
   localparam int STAT_CPU_SYS_BIT = 3;
   localparam int IRQ_FAIL_BIT = 0;
   localparam int IRQ_READY_BIT = 1;
   localparam int IRQ_W = 2;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage : scs_pkg

// ### hw/scs_top.sv
// Purpose: system, peripheral and cpu clock selection with crystal failover
// Assumes: oscillator levels arrive synchronous to pclk, well below its rate
// Notes: output clocks are pclk-sampled copies or divisions of the oscillator waveforms
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module scs_top
   import scs_pkg::*;
#(
   parameter int START_MAX_CYC = XTAL_START_MAX_CYC, // start wait at max bias
   parameter int START_OPT_CYC = XTAL_START_OPT_CYC, // start wait at other bias
   parameter int FAIL_CYC = XTAL_FAIL_CYC // edge-less time counted as failure
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fast_rc_osc,
   input wire logic main_crystal_osc,
   input wire logic slow_rc_osc,
   input wire logic watch_crystal_osc,
   input wire logic slow_xtal_pin_b,
   input wire logic flash_busy,
   output logic main_sys_clock,
   output logic periph_clock,
   output logic cpu_core_clock,
   output logic one_khz_ref,
   output logic watch_clock,
   output logic [4:0] fast_rc_trim,
   output logic [3:0] xtal_bias,
   output logic xtal_enable,
   output logic nmi,
   output logic irq
);
   localparam int CNT_W = 18;
   // elaboration checks: counts that the counters cannot hold are refused
   if (START_MAX_CYC < 1 || START_MAX_CYC >= 2 ** CNT_W || START_OPT_CYC < 1 || START_OPT_CYC >= 2 ** CNT_W)
      $error("start-up count out of range");
   if (FAIL_CYC < 2 || FAIL_CYC > 255)
      $error("failure count out of range");
   // apb state
   logic pready_reg; // access answered
   logic pslverr_reg; // unmapped access
   logic [31:0] prdata_reg; // captured read data
   logic access; // first access cycle
   logic done; // completing edge of a transfer
   logic wr_done; // write takes effect
   logic rd_done; // read completes
   // software registers
   logic [3:0] ctrl_reg; // select, enable and pin mode bits
   logic [4:0] trim_rc_reg; // fast rc trim code
   logic [3:0] bias_reg; // crystal bias
   logic [FRAC_W-1:0] frac_reg; // divider ratio
   logic [IRQ_W-1:0] irq_stat_reg; // sticky events
   logic [IRQ_W-1:0] irq_mask_reg; // event enables
   // crystal supervision
   logic xtal_ready_reg; // crystal started and alive
   logic fail_latch_reg; // failure seen, held until disable
   logic [CNT_W-1:0] start_cnt_reg; // start-up wait counter
   logic [7:0] edge_cnt_reg; // cycles since last crystal edge
   logic xtal_prev_reg; // crystal level one cycle ago
   logic fail_evt; // one-cycle failure
   logic ready_evt; // one-cycle ready
   logic [CNT_W-1:0] start_limit; // wait for the chosen bias
   // clock tree
   logic src_xtal_reg; // system clock taken from crystal
   logic src_want; // wanted system source
   logic sys_clk_reg; // system clock copy
   logic sys_prev_reg; // system clock one cycle ago
   logic per_clk_reg; // peripheral clock copy
   logic cpu_src_reg; // cpu clock from system (1) or peripheral (0)
   logic cpu_want; // wanted cpu source
   logic cpu_clk_reg; // cpu clock copy
   logic slow_prev_reg; // slow rc level one cycle ago
   logic watch_reg; // watch clock copy
   logic nmi_reg; // failure pulse
   logic irq_reg; // combined interrupt
   logic ref_clk; // from the divider

   function automatic logic [31:0] pad_word(input logic [15:0] v);
      pad_word = {16'h0000, v};
   endfunction : pad_word
   // apb strobes
   always_comb begin
      access = psel && penable && !pready_reg;
      done = psel && penable && pready_reg;
      wr_done = done && pwrite && !pslverr_reg;
      rd_done = done && !pwrite && !pslverr_reg;
   end
   // answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= access;
      end
   end
   // read data and error captured in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (access) begin
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         if (paddr == CTRL_OFS) begin
            prdata_reg <= pad_word({12'h000, ctrl_reg});
         end else if (paddr == TRIM_OFS) begin
            prdata_reg <= pad_word({4'h0, bias_reg, 3'h0, trim_rc_reg});
         end else if (paddr == FRAC_OFS) begin
            prdata_reg <= pad_word(frac_reg);
         end else if (paddr == STAT_OFS) begin
            prdata_reg <= pad_word({12'h000, cpu_src_reg, flash_busy, xtal_ready_reg, src_xtal_reg});
         end else if (paddr == IRQ_STAT_OFS) begin
            prdata_reg <= pad_word({14'h0000, irq_stat_reg});
         end else if (paddr == IRQ_MASK_OFS) begin
            prdata_reg <= pad_word({14'h0000, irq_mask_reg});
         end else begin
            // unmapped: error, zero data
            pslverr_reg <= 1'b1;
         end
      end
   end
   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_done && paddr == CTRL_OFS) begin
         ctrl_reg <= pwdata[3:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_rc_reg <= TRIM_RC_RESET;
         bias_reg <= TRIM_BIAS_RESET;
      end else if (wr_done && paddr == TRIM_OFS) begin
         trim_rc_reg <= pwdata[TRIM_RC_LSB +: TRIM_RC_W];
         bias_reg <= pwdata[TRIM_BIAS_LSB +: TRIM_BIAS_W];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frac_reg <= FRAC_RESET;
      end else if (wr_done && paddr == FRAC_OFS) begin
         frac_reg <= pwdata[FRAC_W-1:0];
      end
   end
   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= IRQ_RESET;
      end else if (wr_done && paddr == IRQ_MASK_OFS) begin
         irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
   end
   // sticky events, read clears; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= IRQ_RESET;
      end else begin
         irq_stat_reg <= ((rd_done && paddr == IRQ_STAT_OFS) ? IRQ_RESET : irq_stat_reg)
                         | {ready_evt, fail_evt};
      end
   end
   always_comb begin
      start_limit = (bias_reg == TRIM_BIAS_MAX) ? START_MAX_CYC[CNT_W-1:0] : START_OPT_CYC[CNT_W-1:0];
      ready_evt = ctrl_reg[CTRL_XTAL_EN_BIT] && !xtal_ready_reg && !fail_latch_reg
                  && (start_cnt_reg == start_limit - 1'b1);
      fail_evt = xtal_ready_reg && (main_crystal_osc == xtal_prev_reg)
                 && (edge_cnt_reg == FAIL_CYC[7:0] - 8'h01);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_cnt_reg <= '0;
      end else if (!ctrl_reg[CTRL_XTAL_EN_BIT] || xtal_ready_reg || fail_latch_reg || ready_evt) begin
         start_cnt_reg <= '0;
      end else begin
         start_cnt_reg <= start_cnt_reg + 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_reg <= 8'h00;
         xtal_prev_reg <= 1'b0;
      end else begin
         xtal_prev_reg <= main_crystal_osc;
         if (!xtal_ready_reg || main_crystal_osc != xtal_prev_reg) begin
            edge_cnt_reg <= 8'h00;
         end else begin
            edge_cnt_reg <= edge_cnt_reg + 8'h01;
         end
      end
   end
   // ready drops on failure; latch held until software disables the crystal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_ready_reg <= 1'b0;
         fail_latch_reg <= 1'b0;
      end else begin
         if (fail_evt) begin
            fail_latch_reg <= 1'b1;
         end else if (!ctrl_reg[CTRL_XTAL_EN_BIT]) begin
            fail_latch_reg <= 1'b0;
         end
         if (fail_evt || !ctrl_reg[CTRL_XTAL_EN_BIT]) begin
            xtal_ready_reg <= 1'b0;
         end else if (ready_evt) begin
            xtal_ready_reg <= 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         nmi_reg <= fail_evt;
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end
   // crystal only when selected and running
   // flash forces 12 MHz: rc system clock or crystal peripheral clock
   always_comb begin
      src_want = ctrl_reg[CTRL_OSC_SEL_BIT] && xtal_ready_reg;
      if (flash_busy) begin
         cpu_want = !src_xtal_reg;
      end else begin
         cpu_want = ctrl_reg[CTRL_CPU_SEL_BIT];
      end
   end
   // system source swaps only with old, new and output all low
   // a failed crystal may be stuck high, so then only the rc level counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_xtal_reg <= 1'b0;
         sys_clk_reg <= 1'b0;
         sys_prev_reg <= 1'b0;
      end else begin
         sys_prev_reg <= sys_clk_reg;
         sys_clk_reg <= src_xtal_reg ? main_crystal_osc : fast_rc_osc;
         // after a failure the output has stood still for the whole failure time, so cutting it is no runt
         if (src_xtal_reg != src_want && !fast_rc_osc
             && (fail_latch_reg || (!sys_clk_reg && !main_crystal_osc))) begin
            src_xtal_reg <= src_want;
         end
      end
   end
   // peripheral clock toggles on each system rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_clk_reg <= 1'b0;
      end else if (sys_clk_reg && !sys_prev_reg) begin
         per_clk_reg <= ~per_clk_reg;
      end
   end
   // swap only while both inputs and output are low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_src_reg <= 1'b0;
         cpu_clk_reg <= 1'b0;
      end else begin
         cpu_clk_reg <= cpu_src_reg ? sys_clk_reg : per_clk_reg;
         if (cpu_src_reg != cpu_want && !cpu_clk_reg && !sys_clk_reg && !per_clk_reg) begin
            cpu_src_reg <= cpu_want;
         end
      end
   end

   // watch clock from pin or crystal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watch_reg <= 1'b0;
         slow_prev_reg <= 1'b0;
      end else begin
         watch_reg <= ctrl_reg[CTRL_PIN_DIG_BIT] ? slow_xtal_pin_b : watch_crystal_osc;
         slow_prev_reg <= slow_rc_osc;
      end
   end

   scs_frac_div u_frac_div (
      .pclk(pclk),
      .presetn(presetn),
      .slow_tick(slow_rc_osc && !slow_prev_reg),
      .half_ratio(frac_reg),
      .ref_clk_reg(ref_clk)
   );

   // outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign main_sys_clock = sys_clk_reg;
   assign periph_clock = per_clk_reg;
   assign cpu_core_clock = cpu_clk_reg;
   assign one_khz_ref = ref_clk;
   assign watch_clock = watch_reg;
   assign fast_rc_trim = trim_rc_reg;
   assign xtal_bias = bias_reg;
   assign xtal_enable = ctrl_reg[CTRL_XTAL_EN_BIT];
   assign nmi = nmi_reg;
   assign irq = irq_reg;
   // rc stays source until crystal ready
   a_rc_from_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !src_xtal_reg && !xtal_ready_reg |=> !src_xtal_reg)
      else $error("system clock left rc without a ready crystal");
   // failure raises nmi and falls back
   a_fail_nmi: assert property (@(posedge pclk) disable iff (!presetn)
      fail_evt |-> ##1 nmi && !xtal_ready_reg ##[0:200] !src_xtal_reg)
      else $error("crystal failure without nmi or fallback");
   a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(src_xtal_reg) |-> $past(ctrl_reg[CTRL_OSC_SEL_BIT]) && $past(xtal_ready_reg))
      else $error("crystal chosen without select bit");
   a_per_half: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(per_clk_reg) |-> $past(sys_clk_reg) && !$past(sys_prev_reg))
      else $error("peripheral clock toggled off a system edge");
   a_cpu_follow: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_src_reg != cpu_want |-> ##[0:300] (cpu_src_reg == cpu_want || $changed(cpu_want)))
      else $error("cpu clock source never followed the select");
   // flash moves the cpu onto the 12 MHz branch
   a_flash_force: assert property (@(posedge pclk) disable iff (!presetn)
      flash_busy && cpu_src_reg == src_xtal_reg |-> ##[1:40] (!flash_busy || cpu_src_reg != src_xtal_reg))
      else $error("flash busy without forced cpu clock");
   a_trim_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && paddr == TRIM_OFS |=> fast_rc_trim == $past(pwdata[4:0]) && xtal_bias == $past(pwdata[11:8]))
      else $error("trim write lost");
   a_watch_pin: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 watch_clock == ($past(ctrl_reg[CTRL_PIN_DIG_BIT]) ? $past(slow_xtal_pin_b) : $past(watch_crystal_osc)))
      else $error("watch clock from wrong source");
   // ready only after the full wait
   a_start_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(xtal_ready_reg) |-> $past(start_cnt_reg) == $past(start_limit) - 1'b1)
      else $error("crystal ready before start-up wait");
   // system clock edges come only from the source in use
   a_sys_glitch: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(sys_clk_reg) |-> sys_clk_reg == ($past(src_xtal_reg) ? $past(main_crystal_osc) : $past(fast_rc_osc)))
      else $error("system clock edge not from its source");
endmodule : scs_top

// ### tb/test_scs_top.sv
// Purpose: self-checking bench for the system clock switching block
// Assumes: oscillators are modelled as pclk-divided levels; short crystal waits
// Notes: clock rates are judged by counting rising edges, or toggles for the 1 kHz reference, over a fixed span
`timescale 1ns/1ps
module test_scs_top;
   import scs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flash_busy = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, xtal_run = 0;
   logic fast_rc_osc = 0, main_crystal_osc = 0, slow_rc_osc = 0, watch_crystal_osc = 0, slow_xtal_pin_b = 0;
   logic main_sys_clock, periph_clock, cpu_core_clock, one_khz_ref, watch_clock, xtal_enable, nmi, irq;
   logic [4:0] fast_rc_trim;
   logic [3:0] xtal_bias;
   logic [7:0] cnt = 8'h00; // divider for all oscillator models
   int fail_count = 0, n_compared = 0;
   // short start and fail counts keep the run brief
   scs_top #(.START_MAX_CYC(20), .START_OPT_CYC(40), .FAIL_CYC(16)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fast_rc_osc(fast_rc_osc), .main_crystal_osc(main_crystal_osc),
      .slow_rc_osc(slow_rc_osc), .watch_crystal_osc(watch_crystal_osc), .slow_xtal_pin_b(slow_xtal_pin_b),
      .flash_busy(flash_busy), .main_sys_clock(main_sys_clock), .periph_clock(periph_clock),
      .cpu_core_clock(cpu_core_clock), .one_khz_ref(one_khz_ref), .watch_clock(watch_clock),
      .fast_rc_trim(fast_rc_trim), .xtal_bias(xtal_bias), .xtal_enable(xtal_enable), .nmi(nmi), .irq(irq));
   always #5 pclk = ~pclk;
   // oscillators: rc period 8, crystal 4, slow rc 16, watch 32, pin 64
   always @(posedge pclk) begin
      cnt <= cnt + 8'h01;
      fast_rc_osc <= cnt[2];
      main_crystal_osc <= xtal_run ? cnt[1] : main_crystal_osc; // a stopped crystal holds its level
      slow_rc_osc <= cnt[3];
      watch_crystal_osc <= cnt[4];
      slow_xtal_pin_b <= cnt[5];
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // edge counts carry one edge of slack for phase
   task near(input int got, input int exp, input string what);
      n_compared++;
      if (got < exp - 1 || got > exp + 1) begin
         fail_count++;
         $display("[FAIL] %0t %s rate %0d want %0d", $time, what, got, exp);
      end
   endtask : near
   // one apb transfer, request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) chk(0, 1, "no pready");
      psel <= 0;
      penable <= 0;
   endtask : apb
   task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rchk
   // poll a status bit with a bounded number of reads
   task wait_stat(input int b);
      int n;
      n = 0;
      do begin
         apb(0, STAT_OFS, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < 40);
      chk(rd[b], 1, "status bit never set");
   endtask : wait_stat
   // counts rising edges of system, peripheral, cpu and watch clocks
   task meas(input int n, input int es, input int ep, input int ec, input int ew);
      logic [3:0] pv;
      int c[4];
      // let a requested source switch settle before counting
      repeat (24) @(posedge pclk);
      c = '{0, 0, 0, 0};
      pv = {main_sys_clock, periph_clock, cpu_core_clock, watch_clock};
      repeat (n) begin
         @(posedge pclk);
         if (main_sys_clock && !pv[3]) c[0]++;
         if (periph_clock && !pv[2]) c[1]++;
         if (cpu_core_clock && !pv[1]) c[2]++;
         if (watch_clock && !pv[0]) c[3]++;
         pv = {main_sys_clock, periph_clock, cpu_core_clock, watch_clock};
      end
      near(c[0], es, "sys");
      near(c[1], ep, "periph");
      near(c[2], ec, "cpu");
      near(c[3], ew, "watch");
   endtask : meas
   task t_reset;
      rchk(CTRL_OFS, 32'h0, "ctrl reset");
      rchk(TRIM_OFS, 32'h0f10, "trim reset");
      rchk(FRAC_OFS, 32'h0500, "frac reset");
      rchk(IRQ_MASK_OFS, 32'h0, "mask reset");
      apb(0, 8'h18, 32'h0);
      chk(err, 1, "unmapped err");
      apb(1, TRIM_OFS, 32'h0f03);
      // the write lands at the pready edge; look one edge later
      @(posedge pclk);
      chk({xtal_bias, fast_rc_trim}, 9'h1e3, "trim outputs");
      $display("reset test done");
   endtask : t_reset
   task t_rc;
      meas(160, 20, 10, 10, 5);
      apb(1, CTRL_OFS, 32'h2);
      meas(160, 20, 10, 20, 5);
      apb(1, CTRL_OFS, 32'h0);
      flash_busy <= 1;
      meas(160, 20, 10, 20, 5);
      rchk(STAT_OFS, 32'hc, "flash status");
      flash_busy <= 0;
      apb(1, CTRL_OFS, 32'h8);
      meas(320, 40, 20, 20, 5);
      $display("rc test done");
   endtask : t_rc
   task t_xtal;
      xtal_run <= 1;
      // optimal bias: the longer start-up wait applies
      apb(1, TRIM_OFS, 32'h0703);
      apb(1, CTRL_OFS, 32'h4);
      repeat (30) @(posedge pclk);
      rchk(STAT_OFS, 32'h0, "ready before optimal-bias wait");
      chk(xtal_enable, 1, "crystal enable pin");
      wait_stat(STAT_XTAL_RDY_BIT);
      chk(irq, 0, "masked irq");
      apb(1, IRQ_MASK_OFS, 32'h3);
      repeat (3) @(posedge pclk);
      chk(irq, 1, "ready irq");
      rchk(IRQ_STAT_OFS, 32'h2, "ready event");
      repeat (3) @(posedge pclk);
      chk(irq, 0, "irq cleared");
      apb(1, CTRL_OFS, 32'h5);
      wait_stat(STAT_ON_XTAL_BIT);
      meas(160, 40, 20, 20, 5);
      apb(1, CTRL_OFS, 32'h7);
      meas(160, 40, 20, 40, 5);
      flash_busy <= 1;
      meas(160, 40, 20, 20, 5);
      flash_busy <= 0;
      $display("crystal test done");
   endtask : t_xtal
   task t_fail;
      int n;
      n = 0;
      xtal_run <= 0;
      while (nmi !== 1'b1 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      chk(nmi, 1, "nmi raised");
      @(posedge pclk);
      chk(nmi, 0, "nmi one cycle");
      chk(irq, 1, "fail irq");
      // the fallback waits for a low rc level
      repeat (8) @(posedge pclk);
      rchk(STAT_OFS, 32'h8, "back on rc");
      rchk(IRQ_STAT_OFS, 32'h1, "fail event");
      meas(160, 20, 10, 20, 5);
      $display("failover test done");
   endtask : t_fail
   task t_ref;
      int t;
      logic pv;
      for (int k = 0; k < 2; k++) begin
         if (k == 1) apb(1, FRAC_OFS, 32'h0280);
         repeat (4) @(posedge pclk);
         t = 0;
         pv = one_khz_ref;
         repeat (800) begin
            @(posedge pclk);
            if (one_khz_ref !== pv) t++;
            pv = one_khz_ref;
         end
         near(t, k ? 20 : 10, "ref toggles");
      end
      $display("reference test done");
   endtask : t_ref
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // reset for six cycles, then the scenarios in order
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_rc;
      t_xtal;
      t_fail;
      t_ref;
      tally_and_finish;
   end
   // watchdog: far beyond the few thousand cycles the tests need
   initial begin
      #200000;
      fail_count++;
      tally_and_finish;
   end
endmodule : test_scs_top
